// ==== dmai_irq_top.sv ====
// dma channel interrupt request logic with its apb register file
//
// Overview of operation
// RULE_01: each of eight channels has two sources
// RULE_02: end request equals end flag and enable
// RULE_03: half request equals half flag and enable
// RULE_04: writing a flag to zero withdraws request
// RULE_05: every request has its own output line
// RULE_06: end source outranks half source per channel
// RULE_07: interrupt controller ranks channels by programming
// RULE_08: half flag at half count, end at full
`timescale 1ns/1ps
`default_nettype none
module dmai_irq_top
   import dmai_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [DATA_W-1:0] I_PWDATA,
   output logic [DATA_W-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // transfer engine: one pulse per unit moved on each channel
   input wire logic [NUM_CHAN-1:0] I_XFER_STEP,
   // engine side view of each channel
   output logic [NUM_CHAN-1:0] O_CHAN_BUSY,
   // to the interrupt controller
   output logic [NUM_CHAN-1:0] O_END_REQ,
   output logic [NUM_CHAN-1:0] O_HALF_REQ,
   output logic [2*NUM_CHAN-1:0] O_CHAN_TOP_SRC
);

   // ****************************************************************
   // bus decode
   // ****************************************************************
   dmai_apb_req_type req;              // the bus request as one carrier
   logic [CHAN_W-1:0] chan_sel;        // addressed channel
   logic [REG_W-1:0] reg_sel;          // addressed register in the slot
   logic is_status;                    // status word addressed
   logic is_chan;                      // a channel register addressed
   logic addr_ok;                      // address is mapped
   logic setup_phase;                  // first cycle of a transfer
   logic access_phase;                 // completing cycle of a transfer
   logic wr_en;                        // write takes effect at this edge

   assign req.sel = I_PSEL;
   assign req.enable = I_PENABLE;
   assign req.write = I_PWRITE;
   assign req.addr = I_PADDR;
   assign req.wdata = I_PWDATA;

   assign chan_sel = req.addr[CHAN_LSB +: CHAN_W];
   assign reg_sel = req.addr[REG_LSB +: REG_W];
   assign is_status = (req.addr == STATUS_ADDR);
   // slot word 3 is a hole, and unaligned addresses are not mapped
   assign is_chan = (req.addr < STATUS_ADDR) && (reg_sel != 2'h3)
                    && (req.addr[1:0] == ALIGN_ZERO);
   assign addr_ok = is_status || is_chan;
   assign setup_phase = req.sel && !req.enable;
   assign access_phase = req.sel && req.enable;
   // unmapped writes are dropped and answered with an error
   assign wr_en = access_phase && req.write && addr_ok;

   // no wait states: every access completes in its first access cycle
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = access_phase && !addr_ok;

   // ****************************************************************
   // per-channel state
   // ****************************************************************
   logic [NUM_CHAN-1:0][4:0] ctrl_v;          // control words, flattened
   logic [NUM_CHAN-1:0][CNT_W-1:0] count_v;   // programmed counts
   logic [NUM_CHAN-1:0][CNT_W-1:0] remain_v;  // remaining counts
   logic [NUM_CHAN-1:0] busy_v;               // counting channels
   logic [NUM_CHAN-1:0] next_end_req;         // end request about to be
   logic [NUM_CHAN-1:0] next_half_req;        // half request about to be
   logic [NUM_CHAN-1:0][1:0] top_src;         // ranked source per channel

   for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      dmai_ctrl_type ctrl, next_ctrl;         // flags and enables
      logic [CNT_W-1:0] count, next_count;    // programmed count
      logic ctrl_wr;                          // this channel's control written
      logic count_wr;                         // this channel's count written
      logic start;                            // start pulse to the counter
      logic stop;                             // abort pulse to the counter
      logic half_hit;                         // counter reached half
      logic end_hit;                          // counter reached the end

      assign ctrl_wr = wr_en && is_chan && (chan_sel == CHAN_W'(ch))
                       && (reg_sel == REG_CTRL);
      assign count_wr = wr_en && is_chan && (chan_sel == CHAN_W'(ch))
                        && (reg_sel == REG_COUNT);
      assign start = ctrl_wr && req.wdata[BIT_START];
      // start bit reads back as busy, so a read-modify-write that only
      // clears a flag keeps a running channel going
      assign stop = ctrl_wr && !req.wdata[BIT_START];

      // transfer counter of this channel
      dmai_chan_count u_count (
         .i_clock(I_CLOCK),
         .i_rst(I_RST),
         .i_start(start),
         .i_stop(stop),
         .i_count(count),
         .i_step(I_XFER_STEP[ch]),
         .o_busy(busy_v[ch]),
         .o_remain(remain_v[ch]),
         .o_half_hit(half_hit),
         .o_end_hit(end_hit)
      );

      // next flags, enables and count
      always_comb begin
         next_ctrl = ctrl;
         next_count = count;
         if (ctrl_wr) begin
            next_ctrl.end_irq_enable = req.wdata[BIT_END_IE];
            next_ctrl.half_irq_enable = req.wdata[BIT_HALF_IE];
            // flags only clear by writing zero; writing one leaves them
            if (!req.wdata[BIT_END_FLAG]) begin
               next_ctrl.end_flag = 1'b0;     // [RULE_04]
            end
            if (!req.wdata[BIT_HALF_FLAG]) begin
               next_ctrl.half_flag = 1'b0;    // [RULE_04]
            end
         end
         if (count_wr) begin
            next_count = req.wdata[CNT_W-1:0];
         end
         // hardware set comes last so an event in the clearing cycle wins
         if (end_hit) begin
            next_ctrl.end_flag = 1'b1;        // [RULE_08]
         end
         if (half_hit) begin
            next_ctrl.half_flag = 1'b1;       // [RULE_08]
         end
         next_ctrl.start = 1'b0;              // start lives in the counter
      end

      // requests follow the flags on the same edge, so a cleared flag
      // and its withdrawn request show together
      assign next_end_req[ch] = next_ctrl.end_flag && next_ctrl.end_irq_enable;     // [RULE_02]
      assign next_half_req[ch] = next_ctrl.half_flag && next_ctrl.half_irq_enable;  // [RULE_03]

      // register flags, enables and count
      always_ff @(posedge I_CLOCK) begin
         if (I_RST) begin
            ctrl <= CTRL_RESET;
            count <= COUNT_RESET;
         end else begin
            ctrl <= next_ctrl;
            count <= next_count;
         end
      end

      assign ctrl_v[ch] = ctrl;
      assign count_v[ch] = count;
   end

   // ****************************************************************
   // request outputs
   // ****************************************************************
   dmai_src_rank u_rank (
      .i_end_req(next_end_req),
      .i_half_req(next_half_req),
      .o_top_src(top_src)
   );

   logic [NUM_CHAN-1:0] end_req, half_req;   // registered requests
   logic [2*NUM_CHAN-1:0] top_src_q;          // registered ranking

   // requests leave from flops, each on its own line
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         end_req <= '0;
         half_req <= '0;
         top_src_q <= '0;
      end else begin
         end_req <= next_end_req;             // [RULE_01] [RULE_05]
         half_req <= next_half_req;           // [RULE_01] [RULE_05]
         top_src_q <= top_src;                // [RULE_06]
      end
   end

   // no merging: the interrupt controller ranks channels itself [RULE_07]
   assign O_END_REQ = end_req;
   assign O_HALF_REQ = half_req;
   assign O_CHAN_TOP_SRC = top_src_q;
   assign O_CHAN_BUSY = busy_v;

   // ****************************************************************
   // read data
   // ****************************************************************
   logic [DATA_W-1:0] rdata, next_rdata;     // read data register
   logic [4:0] ctrl_rd;                       // control word as read

   // read data is caught in the setup cycle and shown in the access cycle;
   // a flag that sets in between shows on the next read
   always_comb begin
      next_rdata = rdata;
      ctrl_rd = ctrl_v[chan_sel];
      ctrl_rd[BIT_START] = busy_v[chan_sel];
      if (setup_phase) begin
         next_rdata = RDATA_ZERO;             // unmapped and reserved read zero
         if (is_status) begin
            next_rdata[NUM_CHAN-1:0] = end_req;
            next_rdata[STAT_HALF_LSB +: NUM_CHAN] = half_req;
         end else if (is_chan) begin
            unique case (reg_sel)
               REG_CTRL: next_rdata[4:0] = ctrl_rd;
               REG_COUNT: next_rdata[CNT_W-1:0] = count_v[chan_sel];
               REG_REMAIN: next_rdata[CNT_W-1:0] = remain_v[chan_sel];
               default: next_rdata = RDATA_ZERO;
            endcase
         end
      end
   end

   // register read data
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         rdata <= RDATA_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign O_PRDATA = rdata;

endmodule : dmai_irq_top
`default_nettype wire

// ==== dmai_pkg.sv ====
// shared constants, register map and types of the dma channel interrupt request block
package dmai_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int NUM_CHAN = 8;   // channels 0 through 7
   localparam int CNT_W = 16;     // transfer count width
   localparam int ADDR_W = 8;     // apb byte address width
   localparam int DATA_W = 32;    // apb data width

   // ****************************************************************
   // register map: one 16-byte slot per channel, status word above
   // ****************************************************************
   localparam int CHAN_LSB = 4;   // channel index sits in paddr[6:4]
   localparam int CHAN_W = 3;     // bits of channel index
   localparam int REG_LSB = 2;    // register index sits in paddr[3:2]
   localparam int REG_W = 2;      // bits of register index
   localparam logic [REG_W-1:0] REG_CTRL = 2'h0;    // channel_control_reg
   localparam logic [REG_W-1:0] REG_COUNT = 2'h1;   // programmed count
   localparam logic [REG_W-1:0] REG_REMAIN = 2'h2;  // remaining count, read only
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h80;  // request summary, read only
   localparam logic [1:0] ALIGN_ZERO = 2'h0;        // word alignment of paddr[1:0]

   // ****************************************************************
   // channel_control_reg fields
   // ****************************************************************
   localparam int BIT_START = 0;       // write 1 starts, 0 stops; reads busy
   localparam int BIT_END_FLAG = 1;    // end_flag, write 0 clears
   localparam int BIT_END_IE = 2;      // end_irq_enable
   localparam int BIT_HALF_IE = 3;     // half_irq_enable
   localparam int BIT_HALF_FLAG = 4;   // half_flag, write 0 clears
   localparam int STAT_HALF_LSB = 8;   // status: half requests in [15:8]

   // field order matches the bit positions above, msb first
   typedef struct packed {
      logic half_flag;
      logic half_irq_enable;
      logic end_irq_enable;
      logic end_flag;
      logic start;
   } dmai_ctrl_type;

   localparam dmai_ctrl_type CTRL_RESET = 5'h00;    // all clear after reset
   localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;

   // highest pending source inside one channel
   typedef enum logic [1:0] {
      SRC_NONE = 2'h0,
      SRC_END = 2'h1,
      SRC_HALF = 2'h2
   } dmai_src_type;

   // counter states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } dmai_state_type;

   // one apb request as seen by the slave
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dmai_apb_req_type;

endpackage : dmai_pkg

// ==== dmai_chan_count.sv ====
// per-channel transfer counter that reports half and full completion
`timescale 1ns/1ps
`default_nettype none
module dmai_chan_count
   import dmai_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_start,               // one-cycle start request
   input wire logic i_stop,                // one-cycle abort request
   input wire logic [CNT_W-1:0] i_count,   // units to transfer
   input wire logic i_step,                // one unit moved by the engine
   output logic o_busy,                    // counting
   output logic [CNT_W-1:0] o_remain,      // units still to go
   output logic o_half_hit,                // pulse: half of the count done
   output logic o_end_hit                  // pulse: whole count done
);

   // ****************************************************************
   // counter state
   // ****************************************************************
   dmai_state_type state, next_state;
   logic [CNT_W-1:0] remain, next_remain;
   logic [CNT_W-1:0] half_mark, next_half_mark;   // remaining value at half point
   logic half_hit, next_half_hit;
   logic end_hit, next_end_hit;
   logic [CNT_W-1:0] dec_remain;                  // remaining after one step

   // next values; a count of zero is refused and the channel stays idle
   always_comb begin
      next_state = state;
      next_remain = remain;
      next_half_mark = half_mark;
      next_half_hit = 1'b0;
      next_end_hit = 1'b0;
      dec_remain = remain - 16'h0001;
      unique case (state)
         ST_IDLE: begin
            if (i_start && (i_count != COUNT_RESET)) begin
               next_state = ST_RUN;
               next_remain = i_count;
               next_half_mark = i_count >> 1;   // odd counts: half lands after the middle
            end
         end
         ST_RUN: begin
            if (i_stop) begin
               next_state = ST_IDLE;            // abort sets no flag
            end else if (i_step) begin
               next_remain = dec_remain;
               // a count of one reaches half and end on the same step
               if (dec_remain == half_mark) begin
                  next_half_hit = 1'b1;         // [RULE_08]
               end
               if (dec_remain == COUNT_RESET) begin
                  next_end_hit = 1'b1;          // [RULE_08]
                  next_state = ST_IDLE;
               end
            end
         end
      endcase
   end

   // register the counter
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= ST_IDLE;
         remain <= COUNT_RESET;
         half_mark <= COUNT_RESET;
         half_hit <= 1'b0;
         end_hit <= 1'b0;
      end else begin
         state <= next_state;
         remain <= next_remain;
         half_mark <= next_half_mark;
         half_hit <= next_half_hit;
         end_hit <= next_end_hit;
      end
   end

   assign o_busy = (state == ST_RUN);
   assign o_remain = remain;
   assign o_half_hit = half_hit;
   assign o_end_hit = end_hit;

endmodule : dmai_chan_count
`default_nettype wire

// ==== dmai_src_rank.sv ====
// fixed ranking of the two request sources inside each channel
`timescale 1ns/1ps
`default_nettype none
module dmai_src_rank
   import dmai_pkg::*;
(
   input wire logic [NUM_CHAN-1:0] i_end_req,      // transfer end requests
   input wire logic [NUM_CHAN-1:0] i_half_req,     // half end requests
   output logic [NUM_CHAN-1:0][1:0] o_top_src      // dmai_src_type per channel
);

   // ****************************************************************
   // per-channel ranking
   // ****************************************************************
   // channels are not ranked against each other here; that is left to the
   // interrupt controller, which holds its own programmable priorities
   for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_rank
      always_comb begin
         if (i_end_req[ch]) begin
            o_top_src[ch] = SRC_END;    // end outranks half [RULE_06]
         end else if (i_half_req[ch]) begin
            o_top_src[ch] = SRC_HALF;   // [RULE_06]
         end else begin
            o_top_src[ch] = SRC_NONE;
         end
      end
   end

endmodule : dmai_src_rank
`default_nettype wire

// ==== dmai_irq_checker.sv ====
// concurrent checks on the ports of the dma channel interrupt request block
`timescale 1ns/1ps
`default_nettype none
module dmai_irq_checker
   import dmai_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [DATA_W-1:0] I_PWDATA,
   input wire logic [DATA_W-1:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic [NUM_CHAN-1:0] I_XFER_STEP,
   input wire logic [NUM_CHAN-1:0] O_CHAN_BUSY,
   input wire logic [NUM_CHAN-1:0] O_END_REQ,
   input wire logic [NUM_CHAN-1:0] O_HALF_REQ,
   input wire logic [2*NUM_CHAN-1:0] O_CHAN_TOP_SRC
);
   // ****************************************************************
   // helper logic
   // ****************************************************************
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   logic wr_ctrl;                              // control write completes at this edge
   logic [CHAN_W-1:0] wr_ch;                   // channel addressed by that write
   logic [2*NUM_CHAN-1:0] exp_top;             // expected top source per channel
   logic [2*NUM_CHAN-1:0] req_all;             // status word image of the requests
   logic [NUM_CHAN-1:0] step_d;                // step pulses one edge late
   logic [NUM_CHAN-1:0] next_step_d;
   // decode and ranking; end outranks half inside each channel
   always_comb begin
      wr_ctrl = I_PSEL && I_PENABLE && I_PWRITE && !I_PADDR[7] && I_PADDR[3:2] == REG_CTRL
         && I_PADDR[1:0] == ALIGN_ZERO;
      wr_ch = I_PADDR[CHAN_LSB +: CHAN_W];
      req_all = {O_HALF_REQ, O_END_REQ};
      exp_top = '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         exp_top[2*c +: 2] = O_END_REQ[c] ? SRC_END : (O_HALF_REQ[c] ? SRC_HALF : SRC_NONE);
      end
      next_step_d = I_XFER_STEP;
   end
   // a step one edge earlier sets a flag at the clear edge, and set wins, so skip it
   always_ff @(posedge I_CLOCK) begin
      step_d <= next_step_d;
   end
   // ****************************************************************
   // properties
   // ****************************************************************
   sequence s_status_setup;
      I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == STATUS_ADDR;
   endsequence
   property p_end_clear;
      wr_ctrl && !I_PWDATA[BIT_END_FLAG] && !step_d[wr_ch] |=> !O_END_REQ[$past(wr_ch)];
   endproperty
   property p_half_clear;
      wr_ctrl && !I_PWDATA[BIT_HALF_FLAG] && !step_d[wr_ch] |=> !O_HALF_REQ[$past(wr_ch)];
   endproperty
   property p_end_mask;
      wr_ctrl && !I_PWDATA[BIT_END_IE] |=> !O_END_REQ[$past(wr_ch)];
   endproperty
   property p_half_mask;
      wr_ctrl && !I_PWDATA[BIT_HALF_IE] |=> !O_HALF_REQ[$past(wr_ch)];
   endproperty
   property p_end_cause;
      (|(O_END_REQ & ~$past(O_END_REQ))) |-> (|$past(I_XFER_STEP, 2)) || $past(wr_ctrl);
   endproperty
   property p_half_cause;
      (|(O_HALF_REQ & ~$past(O_HALF_REQ))) |-> (|$past(I_XFER_STEP, 2)) || $past(wr_ctrl);
   endproperty
   property p_top_rank;
      O_CHAN_TOP_SRC == exp_top;
   endproperty
   property p_status_lines;
      s_status_setup ##1 (I_PSEL && I_PENABLE) |-> O_PRDATA == {16'h0000, $past(req_all)};
   endproperty
   a_end_clear: assert property (p_end_clear) else $error("end request kept after clear");
   a_half_clear: assert property (p_half_clear) else $error("half request kept after clear");
   a_end_mask: assert property (p_end_mask) else $error("end request while disabled");
   a_half_mask: assert property (p_half_mask) else $error("half request while disabled");
   a_end_cause: assert property (p_end_cause) else $error("end request rose uncaused");
   a_half_cause: assert property (p_half_cause) else $error("half request rose uncaused");
   a_top_rank: assert property (p_top_rank) else $error("top source ranking wrong");
   a_status_lines: assert property (p_status_lines) else $error("status word wrong");
endmodule : dmai_irq_checker
bind dmai_irq_top dmai_irq_checker u_checker (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_XFER_STEP(I_XFER_STEP),
   .O_CHAN_BUSY(O_CHAN_BUSY), .O_END_REQ(O_END_REQ), .O_HALF_REQ(O_HALF_REQ),
   .O_CHAN_TOP_SRC(O_CHAN_TOP_SRC));
`default_nettype wire

// ==== dmai_intc_model.sv ====
// behavioural interrupt controller that grants one of the channel requests
`timescale 1ns/1ps
`default_nettype none
module dmai_intc_model
   import dmai_pkg::*;
(
   input wire logic [NUM_CHAN-1:0] i_end_req,          // transfer end lines
   input wire logic [NUM_CHAN-1:0] i_half_req,         // half end lines
   input wire logic [NUM_CHAN-1:0][2:0] i_chan_level,  // programmed level per channel
   output logic o_grant_valid,                          // some request pending
   output logic [CHAN_W-1:0] o_grant_chan,             // winning channel
   output dmai_src_type o_grant_src                     // winning source of that channel
);
   // ****************************************************************
   // grant selection
   // ****************************************************************
   logic [2:0] best_level;  // level of the current winner
   // ties go to the lower channel, which only matters when levels are equal
   always_comb begin
      best_level = 3'h0;
      o_grant_valid = 1'b0;
      o_grant_chan = '0;
      o_grant_src = SRC_NONE;
      for (int c = 0; c < NUM_CHAN; c++) begin
         if ((i_end_req[c] || i_half_req[c]) && (!o_grant_valid || i_chan_level[c] > best_level)) begin
            o_grant_valid = 1'b1;
            best_level = i_chan_level[c];
            o_grant_chan = CHAN_W'(c);
            o_grant_src = i_end_req[c] ? SRC_END : SRC_HALF;
         end
      end
   end
endmodule : dmai_intc_model
`default_nettype wire

// ==== tb_dma_channel_irq_sources.sv ====
// self-checking bench for the dma channel interrupt request block
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_irq_sources
   import dmai_pkg::*;
;
   // ****************************************************************
   // signals, design and partner
   // ****************************************************************
   logic clk;
   logic rst = 1'b1;
   dmai_apb_req_type req = '0;            // apb request held by the master tasks
   logic [NUM_CHAN-1:0] step = '0;        // engine step pulses
   logic [DATA_W-1:0] prdata, rd;
   logic pready, pslverr, err;
   logic [NUM_CHAN-1:0] busy, end_req, half_req;
   logic [2*NUM_CHAN-1:0] top_src;
   logic [NUM_CHAN-1:0][2:0] level = '0;  // partner priority programming
   logic g_valid;
   logic [CHAN_W-1:0] g_chan;
   dmai_src_type g_src;
   logic [ADDR_W-1:0] base;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   dmai_irq_top dut (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(req.sel), .I_PENABLE(req.enable),
      .I_PWRITE(req.write), .I_PADDR(req.addr), .I_PWDATA(req.wdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_XFER_STEP(step), .O_CHAN_BUSY(busy),
      .O_END_REQ(end_req), .O_HALF_REQ(half_req), .O_CHAN_TOP_SRC(top_src));
   dmai_intc_model u_intc (.i_end_req(end_req), .i_half_req(half_req), .i_chan_level(level),
      .o_grant_valid(g_valid), .o_grant_chan(g_chan), .o_grant_src(g_src));
   // 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         give_verdict();
      end
   end
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   // one apb transfer; the request is held until pready is seen high
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
      @(posedge clk);
      req.enable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      req <= '0;
      #1;
   endtask : apb
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      apb(1'b0, a, '0);
      check(rd, exp, "read data");
   endtask : rdchk
   // one step per set channel, then time for the flag to land
   task automatic pulse(input logic [NUM_CHAN-1:0] m);
      @(posedge clk);
      step <= m;
      @(posedge clk);
      step <= '0;
      repeat (2) @(posedge clk);
      #1;
   endtask : pulse
   task automatic irq(input logic [7:0] e, input logic [7:0] h, input logic [15:0] t);
      check(32'(end_req), 32'(e), "end requests");
      check(32'(half_req), 32'(h), "half requests");
      check(32'(top_src), 32'(t), "top sources");
   endtask : irq
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         rdchk(8'(c * 16), 32'h0);
      end
      rdchk(STATUS_ADDR, 32'h0);
      irq(8'h00, 8'h00, 16'h0000);
      $display("test reset state done");
      // every channel: half then end, then clear each flag in turn
      for (int c = 0; c < NUM_CHAN; c++) begin
         base = 8'(c * 16);
         apb(1'b1, base + 8'h04, 32'h2);
         apb(1'b1, base, 32'h0D);
         check(32'(busy), 32'h1 << c, "busy after start");
         pulse(8'h01 << c);
         irq(8'h00, 8'h01 << c, 16'h2 << (2 * c));
         pulse(8'h01 << c);
         irq(8'h01 << c, 8'h01 << c, 16'h1 << (2 * c));
         rdchk(STATUS_ADDR, 32'h101 << c);
         apb(1'b1, base, 32'h1C);
         irq(8'h00, 8'h01 << c, 16'h2 << (2 * c));
         apb(1'b1, base, 32'h0C);
         irq(8'h00, 8'h00, 16'h0000);
      end
      $display("test per channel sources done");
      // flags with enables off, then enabled late; partner ranks two channels
      apb(1'b1, 8'h34, 32'h4);
      apb(1'b1, 8'h54, 32'h4);
      apb(1'b1, 8'h30, 32'h1);
      apb(1'b1, 8'h50, 32'h1);
      repeat (4) pulse(8'h28);
      irq(8'h00, 8'h00, 16'h0000);
      rdchk(8'h30, 32'h12);
      apb(1'b1, 8'h30, 32'h1E);
      apb(1'b1, 8'h50, 32'h18);
      irq(8'h08, 8'h28, 16'h0840);
      level[3] = 3'h1;
      level[5] = 3'h6;
      #1;
      check(32'({g_valid, g_chan, g_src}), 32'({1'b1, 3'h5, SRC_HALF}), "grant");
      level[3] = 3'h7;
      #1;
      check(32'({g_valid, g_chan, g_src}), 32'({1'b1, 3'h3, SRC_END}), "grant");
      apb(1'b1, 8'h30, 32'h0);
      apb(1'b1, 8'h50, 32'h0);
      irq(8'h00, 8'h00, 16'h0000);
      $display("test masking and ranking done");
      // count of one sets both flags; an abort sets none
      apb(1'b1, 8'h74, 32'h1);
      apb(1'b1, 8'h70, 32'h0D);
      pulse(8'h80);
      irq(8'h80, 8'h80, 16'h4000);
      apb(1'b1, 8'h64, 32'h4);
      apb(1'b1, 8'h60, 32'h0D);
      pulse(8'h40);
      apb(1'b1, 8'h60, 32'h1C);
      repeat (3) pulse(8'h40);
      rdchk(8'h60, 32'h0C);
      irq(8'h80, 8'h80, 16'h4000);
      $display("test count edges done");
      // unmapped places answer with an error and leave registers alone
      apb(1'b1, 8'h0C, 32'hFFFFFFFF);
      check(32'(err), 32'h1, "write error");
      apb(1'b0, 8'h84, 32'h0);
      check(32'(err), 32'h1, "read error");
      check(rd, 32'h0, "read data");
      rdchk(8'h00, 32'h0C);
      $display("test unmapped done");
      give_verdict();
   end
endmodule : tb_dma_channel_irq_sources
`default_nettype wire
